// ===== rtl/baud_tick_gen.sv
`timescale 1ns/1ps
// Produces one enable pulse per sixteenth of a bit at the chosen rate.
module baud_tick_gen #(
	parameter int unsigned CLK_HZ = serial_port_pkg::CLK_HZ,
	parameter int CNT_W = 17
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [3:0] baud_sel,
	output logic tick
);
	logic [CNT_W-1:0] count_ff;
	logic [CNT_W-1:0] nxt_count;
	logic [CNT_W-1:0] limit;
	logic at_end;

	// Divisor rounds down; a select past the table clamps to the top rate.
	function automatic logic [CNT_W-1:0] limit_of(input logic [3:0] s);
		longint unsigned d;
		int unsigned i;
		i = (32'(s) < serial_port_pkg::BAUD_COUNT) ? 32'(s) :
			serial_port_pkg::BAUD_COUNT - 1;
		d = (longint'(CLK_HZ) * 10) / (serial_port_pkg::OVERSAMPLE *
			serial_port_pkg::BAUD_X10[i]);
		if (d < 1) begin
			d = 1;
		end
		return CNT_W'(d - 1);
	endfunction

	// A comparison by >= copes with a rate change mid-count.
	assign limit = limit_of(baud_sel);
	assign at_end = (count_ff >= limit);
	assign nxt_count = at_end ? '0 : count_ff + 1'b1;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			count_ff <= '0;
			tick <= 1'b0;
		end else begin
			count_ff <= nxt_count;
			tick <= at_end;
		end
	end
endmodule

// ===== rtl/char_stream_if.sv
`timescale 1ns/1ps
// Valid/ready character stream between the port and its buffers.
interface char_stream_if #(parameter int W = 7);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface

// ===== rtl/serial_port.sv
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
// Asynchronous character port with clear-to-send and terminal-ready.
module serial_port #(
	parameter int unsigned CLK_HZ = serial_port_pkg::CLK_HZ
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic rxd_in,
	output logic txd_out,
	output logic cts_out,
	input wire logic dtr_in
);
	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	localparam int DW = serial_port_pkg::DATA_BITS;
	logic parity_generate_enable_ff;
	logic parity_sense_even_select_ff;
	logic stop_count_select_ff;
	logic rx_en_ff;
	logic [3:0] baud_sel_ff;
	logic dtr_q_ff;
	logic abort_ff;
	logic frame_ff;
	logic overrun_ff;
	logic [7:0] rdata_ff;
	logic txd_ff;
	logic cts_ff;
	serial_port_pkg::tx_state_t tx_st_ff, nxt_tx_st;
	serial_port_pkg::rx_state_t rx_st_ff, nxt_rx_st;
	logic [3:0] tx_tick_ff, nxt_tx_tick;
	logic [3:0] rx_tick_ff, nxt_rx_tick;
	logic [2:0] tx_bit_ff, nxt_tx_bit;
	logic [2:0] rx_bit_ff, nxt_rx_bit;
	logic [DW-1:0] tx_char_ff, nxt_tx_char;
	logic [DW-1:0] rx_shift_ff, nxt_rx_shift;
	logic tick;
	logic abort;
	logic tx_bit_end;
	logic tx_take;
	logic tx_parity;
	logic tx_line;
	logic rx_samp;
	logic rx_mid;
	logic rx_push;
	logic rx_bad_stop;
	logic wr_ctrl;
	logic wr_status;
	logic wr_tx;
	logic rd_rx;
	logic [7:0] ctrl_view;
	logic [7:0] status_view;
	logic [7:0] rd_mux;

	char_stream_if #(.W(DW)) tx_in_if ();
	char_stream_if #(.W(DW)) tx_out_if ();
	char_stream_if #(.W(DW)) rx_in_if ();
	char_stream_if #(.W(DW)) rx_out_if ();

	// ------------------------------------------------------------------
	// Rate generator and buffers
	// ------------------------------------------------------------------
	baud_tick_gen #(.CLK_HZ(CLK_HZ)) u_baud (
		.clk(clk),
		.sys_rst(sys_rst),
		.baud_sel(baud_sel_ff),
		.tick(tick)
	);

	two_entry_buffer #(.W(DW)) u_tx_buf (
		.clk(clk),
		.sys_rst(sys_rst),
		.flush(abort),
		.in_s(tx_in_if),
		.out_s(tx_out_if)
	);

	two_entry_buffer #(.W(DW)) u_rx_buf (
		.clk(clk),
		.sys_rst(sys_rst),
		.flush(abort),
		.in_s(rx_in_if),
		.out_s(rx_out_if)
	);

	// ------------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------------
	assign wr_ctrl = reg_wr && (reg_addr == serial_port_pkg::ADDR_CTRL);
	assign wr_status = reg_wr && (reg_addr == serial_port_pkg::ADDR_STATUS);
	assign wr_tx = reg_wr && (reg_addr == serial_port_pkg::ADDR_TXDATA);
	assign rd_rx = reg_rd && (reg_addr == serial_port_pkg::ADDR_RXDATA);
	assign tx_in_if.valid = wr_tx && dtr_in;
	assign tx_in_if.data = reg_wdata[DW-1:0];
	assign rx_out_if.ready = rd_rx;
	assign ctrl_view = {baud_sel_ff, rx_en_ff, stop_count_select_ff,
		parity_sense_even_select_ff, parity_generate_enable_ff};
	assign status_view = {1'b0, tx_st_ff != serial_port_pkg::TX_IDLE,
		overrun_ff, frame_ff, abort_ff, dtr_in, tx_in_if.ready,
		rx_out_if.valid};
	assign rd_mux =
		(reg_addr == serial_port_pkg::ADDR_CTRL) ? ctrl_view :
		(reg_addr == serial_port_pkg::ADDR_STATUS) ? status_view :
		(rd_rx && rx_out_if.valid) ? {1'b0, rx_out_if.data} : 8'h00;

	// Configuration; the reset values are the delivered setup.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			parity_generate_enable_ff <= serial_port_pkg::PAR_EN_RST;
			parity_sense_even_select_ff <= serial_port_pkg::EVEN_RST;
			stop_count_select_ff <= serial_port_pkg::STOP2_RST;
			rx_en_ff <= serial_port_pkg::RX_EN_RST;
			baud_sel_ff <= serial_port_pkg::BAUD_SEL_RST;
		end else if (wr_ctrl) begin
			parity_generate_enable_ff <=
				reg_wdata[serial_port_pkg::CTRL_PAR_EN_BIT];
			parity_sense_even_select_ff <=
				reg_wdata[serial_port_pkg::CTRL_EVEN_BIT];
			stop_count_select_ff <=
				reg_wdata[serial_port_pkg::CTRL_STOP2_BIT];
			rx_en_ff <= reg_wdata[serial_port_pkg::CTRL_RX_EN_BIT];
			baud_sel_ff <= reg_wdata[serial_port_pkg::CTRL_BAUD_LSB +: 4];
		end
	end

	// Sticky flags: a new event wins over a write-one clear.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dtr_q_ff <= 1'b0;
			abort_ff <= 1'b0;
			frame_ff <= 1'b0;
			overrun_ff <= 1'b0;
			rdata_ff <= 8'h00;
		end else begin
			dtr_q_ff <= dtr_in;
			abort_ff <= abort ||
				(abort_ff && !(wr_status && reg_wdata[serial_port_pkg::ST_ABORT]));
			frame_ff <= rx_bad_stop ||
				(frame_ff && !(wr_status && reg_wdata[serial_port_pkg::ST_FRAME]));
			overrun_ff <= (rx_push && !rx_in_if.ready) || (overrun_ff &&
				!(wr_status && reg_wdata[serial_port_pkg::ST_OVERRUN]));
			rdata_ff <= reg_rd ? rd_mux : 8'h00;
		end
	end

	// ------------------------------------------------------------------
	// Transmitter
	// ------------------------------------------------------------------
	// A dropped terminal-ready aborts everything; carrier detect and data
	// set ready are left unwired on purpose, so nothing can depend on them.
	assign abort = dtr_q_ff && !dtr_in;
	assign tx_bit_end = tick && (tx_tick_ff == 4'hF);
	assign tx_take = (tx_st_ff == serial_port_pkg::TX_IDLE) && tick &&
		dtr_in && tx_out_if.valid;
	assign tx_out_if.ready = tx_take;
	assign tx_parity = (^tx_char_ff) ^ ~parity_sense_even_select_ff;

	// Next state of the transmit sequencer, one bit per sixteen ticks.
	always_comb begin
		nxt_tx_st = tx_st_ff;
		nxt_tx_bit = tx_bit_ff;
		nxt_tx_char = tx_char_ff;
		nxt_tx_tick = tick ? tx_tick_ff + 4'h1 : tx_tick_ff;
		unique case (tx_st_ff)
			serial_port_pkg::TX_IDLE: begin
				nxt_tx_tick = 4'h0;
				if (tx_take) begin
					nxt_tx_st = serial_port_pkg::TX_START;
					nxt_tx_char = tx_out_if.data;
				end
			end
			serial_port_pkg::TX_START: begin
				if (tx_bit_end) begin
					nxt_tx_st = serial_port_pkg::TX_DATA;
					nxt_tx_bit = 3'h0;
				end
			end
			serial_port_pkg::TX_DATA: begin
				if (tx_bit_end && tx_bit_ff == 3'(DW - 1)) begin
					nxt_tx_st = parity_generate_enable_ff ?
						serial_port_pkg::TX_PAR : serial_port_pkg::TX_STOP;
					nxt_tx_bit = 3'h0;
				end else if (tx_bit_end) begin
					nxt_tx_bit = tx_bit_ff + 3'h1;
				end
			end
			serial_port_pkg::TX_PAR: begin
				if (tx_bit_end) begin
					nxt_tx_st = serial_port_pkg::TX_STOP;
				end
			end
			serial_port_pkg::TX_STOP: begin
				if (tx_bit_end && stop_count_select_ff && tx_bit_ff == 3'h0) begin
					nxt_tx_bit = 3'h1;
				end else if (tx_bit_end) begin
					nxt_tx_st = serial_port_pkg::TX_IDLE;
				end
			end
		endcase
		if (!dtr_in) begin
			nxt_tx_st = serial_port_pkg::TX_IDLE;
		end
	end

	// Line level per state; data leave LSB first, idle and stop at mark.
	assign tx_line =
		(tx_st_ff == serial_port_pkg::TX_START) ? 1'b0 :
		(tx_st_ff == serial_port_pkg::TX_DATA) ? tx_char_ff[tx_bit_ff] :
		(tx_st_ff == serial_port_pkg::TX_PAR) ? tx_parity : 1'b1;

	// ------------------------------------------------------------------
	// Receiver
	// ------------------------------------------------------------------
	assign rx_mid = tick && (rx_tick_ff == 4'h7);
	assign rx_samp = tick && (rx_tick_ff == 4'hF);
	assign rx_bad_stop = (rx_st_ff == serial_port_pkg::RX_STOP) &&
		rx_samp && !rxd_in;
	assign rx_push = (rx_st_ff == serial_port_pkg::RX_STOP) && rx_samp &&
		rxd_in && !(stop_count_select_ff && rx_bit_ff == 3'h0);
	assign rx_in_if.valid = rx_push;
	assign rx_in_if.data = rx_shift_ff;

	// Sampling is mid-bit; after the last stop the sequencer waits for
	// a space level on any later tick, so a long stop interval is harmless.
	always_comb begin
		nxt_rx_st = rx_st_ff;
		nxt_rx_bit = rx_bit_ff;
		nxt_rx_shift = rx_shift_ff;
		nxt_rx_tick = tick ? rx_tick_ff + 4'h1 : rx_tick_ff;
		unique case (rx_st_ff)
			serial_port_pkg::RX_IDLE: begin
				nxt_rx_tick = 4'h0;
				if (tick && !rxd_in && rx_en_ff) begin
					nxt_rx_st = serial_port_pkg::RX_START;
				end
			end
			serial_port_pkg::RX_START: begin
				if (rx_mid) begin
					nxt_rx_st = rxd_in ? serial_port_pkg::RX_IDLE :
						serial_port_pkg::RX_DATA;
					nxt_rx_tick = 4'h0;
					nxt_rx_bit = 3'h0;
				end
			end
			serial_port_pkg::RX_DATA: begin
				if (rx_samp) begin
					nxt_rx_shift = {rxd_in, rx_shift_ff[DW-1:1]};
					nxt_rx_bit = rx_bit_ff + 3'h1;
					if (rx_bit_ff == 3'(DW - 1)) begin
						nxt_rx_st = serial_port_pkg::RX_PAR;
					end
				end
			end
			serial_port_pkg::RX_PAR: begin
				// The slot is always skipped and its value ignored.
				if (rx_samp) begin
					nxt_rx_st = serial_port_pkg::RX_STOP;
					nxt_rx_bit = 3'h0;
				end
			end
			serial_port_pkg::RX_STOP: begin
				if (rx_bad_stop || rx_push) begin
					nxt_rx_st = serial_port_pkg::RX_IDLE;
				end else if (rx_samp) begin
					nxt_rx_bit = 3'h1;
				end
			end
		endcase
		if (!dtr_in) begin
			nxt_rx_st = serial_port_pkg::RX_IDLE;
		end
	end

	// ------------------------------------------------------------------
	// Sequencer state and pin registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_st_ff <= serial_port_pkg::TX_IDLE;
			rx_st_ff <= serial_port_pkg::RX_IDLE;
			tx_tick_ff <= 4'h0;
			rx_tick_ff <= 4'h0;
			tx_bit_ff <= 3'h0;
			rx_bit_ff <= 3'h0;
			tx_char_ff <= '0;
			rx_shift_ff <= '0;
			txd_ff <= 1'b1;
			cts_ff <= 1'b0;
		end else begin
			tx_st_ff <= nxt_tx_st;
			rx_st_ff <= nxt_rx_st;
			tx_tick_ff <= nxt_tx_tick;
			rx_tick_ff <= nxt_rx_tick;
			tx_bit_ff <= nxt_tx_bit;
			rx_bit_ff <= nxt_rx_bit;
			tx_char_ff <= nxt_tx_char;
			rx_shift_ff <= nxt_rx_shift;
			txd_ff <= tx_line;
			cts_ff <= rx_en_ff && dtr_in && rx_in_if.ready;
		end
	end

	assign txd_out = txd_ff;
	assign cts_out = cts_ff;
	assign reg_rdata = rdata_ff;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	property p_cts_drop;
		@(posedge clk) disable iff (sys_rst)
		(!dtr_in || !rx_en_ff) |=> !cts_out;
	endproperty
	a_cts_drop: assert property (p_cts_drop)
		else $error("Clear-to-send high while not receiving.");

	property p_abort_idle;
		@(posedge clk) disable iff (sys_rst)
		abort |=> (tx_st_ff == serial_port_pkg::TX_IDLE) &&
			(rx_st_ff == serial_port_pkg::RX_IDLE) && abort_ff;
	endproperty
	a_abort_idle: assert property (p_abort_idle)
		else $error("Terminal-ready fall did not abort.");

	property p_start_space;
		@(posedge clk) disable iff (sys_rst)
		tx_take |=> ##1 !txd_out [*8];
	endproperty
	a_start_space: assert property (p_start_space)
		else $error("Start bit not at space level.");

	property p_idle_mark;
		@(posedge clk) disable iff (sys_rst)
		(tx_st_ff == serial_port_pkg::TX_IDLE) [*2] |-> txd_out;
	endproperty
	a_idle_mark: assert property (p_idle_mark)
		else $error("Idle line not at mark.");

	property p_parity_bit;
		@(posedge clk) disable iff (sys_rst)
		(tx_st_ff == serial_port_pkg::TX_PAR) |=>
			txd_out == ((^tx_char_ff) ^ ~parity_sense_even_select_ff);
	endproperty
	a_parity_bit: assert property (p_parity_bit)
		else $error("Wrong parity level sent.");

	property p_no_parity;
		@(posedge clk) disable iff (sys_rst)
		(tx_st_ff == serial_port_pkg::TX_DATA && tx_bit_end &&
			tx_bit_ff == 3'(DW - 1) && !parity_generate_enable_ff && dtr_in)
			|=> tx_st_ff == serial_port_pkg::TX_STOP;
	endproperty
	a_no_parity: assert property (p_no_parity)
		else $error("Parity slot sent while parity inhibited.");

	property p_two_stops;
		@(posedge clk) disable iff (sys_rst)
		(tx_st_ff == serial_port_pkg::TX_STOP && tx_bit_end &&
			tx_bit_ff == 3'h0 && stop_count_select_ff && dtr_in)
			|=> tx_st_ff == serial_port_pkg::TX_STOP ##1 txd_out;
	endproperty
	a_two_stops: assert property (p_two_stops)
		else $error("Second stop bit missing.");

	property p_rx_push_stop;
		@(posedge clk) disable iff (sys_rst)
		rx_push |-> rxd_in && $past(rx_st_ff) != serial_port_pkg::RX_DATA;
	endproperty
	a_rx_push_stop: assert property (p_rx_push_stop)
		else $error("Character taken without a mark stop.");

	c_tx_char: cover property (@(posedge clk) disable iff (sys_rst)
		tx_st_ff == serial_port_pkg::TX_STOP ##1
		tx_st_ff == serial_port_pkg::TX_IDLE);
	c_rx_char: cover property (@(posedge clk) disable iff (sys_rst)
		rx_push && rx_in_if.ready);
	c_abort: cover property (@(posedge clk) disable iff (sys_rst)
		abort && tx_st_ff != serial_port_pkg::TX_IDLE);
endmodule

// ===== rtl/serial_port_pkg.sv
package serial_port_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned OVERSAMPLE = 16;
	localparam int unsigned BAUD_COUNT = 13;
	// Rates in tenths of a baud, so that 134.5 stays exact.
	localparam int unsigned BAUD_X10 [BAUD_COUNT] = '{
		500, 750, 1100, 1345, 1500, 2000, 3000,
		6000, 12000, 18000, 24000, 48000, 96000};
	localparam int DATA_BITS = 7;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h1;
	localparam logic [3:0] ADDR_TXDATA = 4'h2;
	localparam logic [3:0] ADDR_RXDATA = 4'h3;

	localparam int CTRL_PAR_EN_BIT = 0;
	localparam int CTRL_EVEN_BIT = 1;
	localparam int CTRL_STOP2_BIT = 2;
	localparam int CTRL_RX_EN_BIT = 3;
	localparam int CTRL_BAUD_LSB = 4;

	localparam logic PAR_EN_RST = 1'h1;
	localparam logic EVEN_RST = 1'h1;
	localparam logic STOP2_RST = 1'h0;
	localparam logic RX_EN_RST = 1'h1;
	localparam logic [3:0] BAUD_SEL_RST = 4'hC;

	localparam int ST_RX_VALID = 0;
	localparam int ST_TX_READY = 1;
	localparam int ST_DTR = 2;
	localparam int ST_ABORT = 3;
	localparam int ST_FRAME = 4;
	localparam int ST_OVERRUN = 5;
	localparam int ST_TX_BUSY = 6;

	// ------------------------------------------------------------------
	// State types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR,
		TX_STOP} tx_state_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR,
		RX_STOP} rx_state_t;

endpackage

// ===== rtl/two_entry_buffer.sv
`timescale 1ns/1ps
// Two-word buffer; its full flag is the back-pressure seen upstream.
module two_entry_buffer #(
	parameter int W = 7,
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic flush,
	char_stream_if.snk in_s,
	char_stream_if.src out_s
);
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0] mem_ff [DEPTH];
	logic [PW-1:0] wr_ptr_ff;
	logic [PW-1:0] rd_ptr_ff;
	logic [PW:0] count_ff;
	logic push;
	logic pop;

	assign in_s.ready = (count_ff != (PW+1)'(DEPTH));
	assign out_s.valid = (count_ff != '0);
	assign out_s.data = mem_ff[rd_ptr_ff];
	assign push = in_s.valid && in_s.ready;
	assign pop = out_s.valid && out_s.ready;

	// Pointers wrap at DEPTH; a flush empties the buffer at once.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else if (flush) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= (32'(wr_ptr_ff) == DEPTH - 1) ? '0 :
					wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= (32'(rd_ptr_ff) == DEPTH - 1) ? '0 :
					rd_ptr_ff + 1'b1;
			end
			count_ff <= count_ff + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	// Storage needs no reset; it is only read while valid.
	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_s.data;
		end
	end

	property p_full_holds;
		@(posedge clk) disable iff (sys_rst)
		(!in_s.ready && !out_s.ready && !flush) |=> !in_s.ready;
	endproperty
	a_full_holds: assert property (p_full_holds)
		else $error("Full buffer changed without a pop.");
endmodule

// ===== testbench/async_serial_port_with_modem_lines_bench.sv
`timescale 1ns/1ps
// Self-checking bench; a slow clock rate keeps bit times short.
module async_serial_port_with_modem_lines_bench;
	localparam int unsigned HZ = 614400;
	localparam logic [7:0] TX_CFG [5] = '{8'hCB, 8'hC9, 8'hC8, 8'hCF, 8'hCD};
	localparam logic [7:0] RX_CFG [3] = '{8'hCB, 8'hC8, 8'hCF};
	logic clk;
	logic sys_rst;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic rxd_in;
	logic txd_out;
	logic cts_out;
	logic dtr_in;
	int fail_count = 0;
	int comparisons = 0;
	logic [7:0] got;
	logic [7:0] cfg;
	logic [6:0] ch;
	logic par;
	logic ok;
	logic seen;

	serial_port #(.CLK_HZ(HZ)) u_dut (
		.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .rxd_in(rxd_in), .txd_out(txd_out),
		.cts_out(cts_out), .dtr_in(dtr_in)
	);
	terminal_model u_term (
		.clk(clk), .txd_out(txd_out), .rxd_in(rxd_in), .dtr_in(dtr_in)
	);

	// 100 MHz clock.
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Bus cycles and comparison
	// ------------------------------------------------------------
	task automatic check_val(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] t=%0t got %h expected %h", $time, g, e);
		end
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask

	// Read data stand only in the cycle after the strobe.
	task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1;
		d = reg_rdata;
	endtask

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// A frame that never starts ends the run at once.
	task automatic expect_tx(input logic [7:0] c, input logic [6:0] e);
		u_term.get_char(int'(c[0]), int'(c[2]) + 1, ch, par, ok, seen);
		if (seen !== 1'h1) begin
			fail_count++;
			give_verdict();
		end else begin
			check_val({1'h0, ch}, {1'h0, e});
			check_val({7'h0, ok}, 8'h01);
			if (c[0]) begin
				check_val({7'h0, par}, {7'h0, c[1] ? ^e : ~^e});
			end
		end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		sys_rst = 1'h1;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'h0;
		repeat (3) @(posedge clk);
		#1;
		check_val({6'h0, txd_out, cts_out}, 8'h03);
		reg_read(serial_port_pkg::ADDR_CTRL, got);
		check_val(got, 8'hCB);
		reg_write(4'h9, 8'hFF);
		reg_read(4'h9, got);
		check_val(got, 8'h00);
		reg_read(serial_port_pkg::ADDR_STATUS, got);
		check_val(got, 8'h06);
		// Five framing modes, all but no parity with two stops; two characters back to back.
		for (int i = 0; i < 5; i++) begin
			reg_write(serial_port_pkg::ADDR_CTRL, TX_CFG[i]);
			reg_read(serial_port_pkg::ADDR_CTRL, got);
			check_val(got, TX_CFG[i]);
			reg_write(serial_port_pkg::ADDR_TXDATA, 8'h03);
			reg_write(serial_port_pkg::ADDR_TXDATA, 8'h5A);
			expect_tx(TX_CFG[i], 7'h03);
			expect_tx(TX_CFG[i], 7'h5A);
			repeat (128) @(posedge clk);
		end
		// Bit length follows the selected rate.
		for (int j = 9; j <= 12; j++) begin
			cfg = {j[3:0], 4'hB};
			u_term.bit_clk = 16 * int'(HZ * 10 /
				(16 * serial_port_pkg::BAUD_X10[j]));
			reg_write(serial_port_pkg::ADDR_CTRL, cfg);
			reg_write(serial_port_pkg::ADDR_TXDATA, 8'h41);
			expect_tx(cfg, 7'h41);
			repeat (u_term.bit_clk * 2) @(posedge clk);
		end
		// Receive with a wrong parity value and long stops; fill buffer.
		for (int i = 0; i < 3; i++) begin
			cfg = RX_CFG[i];
			reg_write(serial_port_pkg::ADDR_CTRL, cfg);
			u_term.send_char(7'h35, 1'h1, int'(cfg[2]) + 1);
			u_term.send_char(7'h4C, 1'h0, int'(cfg[2]) + 3);
			repeat (2) @(posedge clk);
			#1;
			check_val({7'h0, cts_out}, 8'h00);
			reg_read(serial_port_pkg::ADDR_STATUS, got);
			check_val(got, 8'h07);
			reg_read(serial_port_pkg::ADDR_RXDATA, got);
			check_val(got, 8'h35);
			reg_read(serial_port_pkg::ADDR_RXDATA, got);
			check_val(got, 8'h4C);
			repeat (2) @(posedge clk);
			#1;
			check_val({7'h0, cts_out}, 8'h01);
		end
		// A third character overruns the full buffer and is lost.
		reg_write(serial_port_pkg::ADDR_CTRL, 8'hCB);
		u_term.send_char(7'h11, 1'h0, 1);
		u_term.send_char(7'h22, 1'h0, 1);
		u_term.send_char(7'h33, 1'h0, 1);
		// No stop bit: the line stays at space past the stop sample, then
		// returns to mark before the false start is validated mid-bit.
		u_term.send_char(7'h44, 1'h0, 0);
		repeat (u_term.bit_clk * 3 / 4) @(posedge clk);
		u_term.rxd_in <= 1'h1;
		repeat (u_term.bit_clk * 2) @(posedge clk);
		reg_read(serial_port_pkg::ADDR_STATUS, got);
		check_val(got, 8'h37);
		reg_read(serial_port_pkg::ADDR_RXDATA, got);
		check_val(got, 8'h11);
		reg_read(serial_port_pkg::ADDR_RXDATA, got);
		check_val(got, 8'h22);
		reg_read(serial_port_pkg::ADDR_RXDATA, got);
		check_val(got, 8'h00);
		reg_write(serial_port_pkg::ADDR_STATUS, 8'h30);
		reg_read(serial_port_pkg::ADDR_STATUS, got);
		check_val(got, 8'h06);
		// With reception disabled, clear-to-send is low and nothing lands.
		reg_write(serial_port_pkg::ADDR_CTRL, 8'hC3);
		repeat (2) @(posedge clk);
		#1;
		check_val({7'h0, cts_out}, 8'h00);
		u_term.send_char(7'h2A, 1'h0, 1);
		reg_read(serial_port_pkg::ADDR_STATUS, got);
		check_val(got, 8'h06);
		reg_write(serial_port_pkg::ADDR_CTRL, 8'hCB);
		// Terminal-ready drops in mid-frame while data bits are space.
		reg_write(serial_port_pkg::ADDR_TXDATA, 8'h00);
		repeat (190) @(posedge clk);
		reg_read(serial_port_pkg::ADDR_STATUS, got);
		check_val(got, 8'h46);
		@(posedge clk);
		u_term.dtr_in <= 1'h0;
		reg_write(serial_port_pkg::ADDR_TXDATA, 8'h00);
		repeat (128) @(posedge clk);
		#1;
		check_val({6'h0, txd_out, cts_out}, 8'h02);
		reg_read(serial_port_pkg::ADDR_STATUS, got);
		check_val(got & 8'h0D, 8'h08);
		@(posedge clk);
		u_term.dtr_in <= 1'h1;
		reg_write(serial_port_pkg::ADDR_STATUS, 8'h08);
		reg_read(serial_port_pkg::ADDR_STATUS, got);
		check_val(got, 8'h06);
		give_verdict();
	end
endmodule

// ===== testbench/terminal_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Terminal side of the link
// ------------------------------------------------------------
// Drives the port's receive line and terminal-ready, and decodes
// the frames the port sends back by sampling each bit mid-way.
module terminal_model (
	input wire logic clk,
	input wire logic txd_out,
	output logic rxd_in,
	output logic dtr_in
);
	int bit_clk = 64;

	// The line idles at mark and the terminal starts connected.
	initial begin
		rxd_in = 1'h1;
		dtr_in = 1'h1;
	end

	// Sends start, seven data bits LSB first, a parity slot whose value
	// is the caller's choice, and any number of mark stop bits.
	task automatic send_char(input logic [6:0] ch, input logic par,
		input int stop_bits);
		logic [10:0] bits;
		bits = {2'h3, par, ch, 1'h0};
		for (int i = 0; i < 9 + stop_bits; i++) begin
			@(posedge clk);
			rxd_in <= (i < 11) ? bits[i] : 1'h1;
			repeat (bit_clk - 1) @(posedge clk);
		end
	endtask

	// Samples on the falling clock edge so the registered line has settled.
	task automatic get_char(input int npar, input int nstop,
		output logic [6:0] ch, output logic par, output logic ok,
		output logic seen);
		int n;
		n = 0;
		ch = 7'h00;
		par = 1'h0;
		while (txd_out !== 1'h0 && n < 40000) begin
			@(negedge clk);
			n++;
		end
		seen = (n < 40000);
		repeat (bit_clk / 2) @(negedge clk);
		ok = (txd_out === 1'h0);
		for (int i = 0; i < 7 + npar + nstop; i++) begin
			repeat (bit_clk) @(negedge clk);
			if (i < 7) begin
				ch[i] = txd_out;
			end else if (i < 7 + npar) begin
				par = txd_out;
			end else begin
				ok = ok & (txd_out === 1'h1);
			end
		end
	endtask
endmodule
